// *** fan_control_gate_register_test.sv ***
// Self-checking bench for the fan control gate register against a behavioural model
`timescale 1ns/1ns
`default_nettype none
module fan_control_gate_register_test;
    import fcg_pkg::*;
    logic        clk, nrst, por_done, adc_ok, wr, rd, start_o, lock_o, ce;
    logic [23:0] dsave;
    logic [4:0]  param_idx;
    logic [23:0] auto_duty, pwm_duty;
    logic [2:0]  pwm_dis;
    logic [7:0]  addr, wdata, rdata, param_data, d;
    logic [31:0] seed = 32'h9a48_f078;
    logic [31:0] tmp;
    int          err_total = 0;
    int          compares = 0;
    int          cycles = 0;
    int          mem [19];
    logic        m_start, m_lock, m_ovr, m_ready;

    fcg_gate_reg uut (.CLK(clk), .NRST(nrst), .CE(ce), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .POR_DONE(por_done), .ADC_OK(adc_ok), .PARAM_IDX(param_idx),
        .PARAM_DATA(param_data), .AUTO_DUTY(auto_duty), .PWM_DISABLED(pwm_dis), .PWM_DUTY(pwm_duty),
        .CTRL_START(start_o), .CTRL_LOCKED(lock_o));
    fcg_host_model host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata));

    // -----------------------------------------------------------------
    // Model and check helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Override and cleared start both force full duty; disabled only matters in auto mode
    function automatic logic [23:0] exp_duty();
        logic [23:0] r;
        for (int c = 0; c < 3; c++) begin
            r[c*8 +: 8] = (m_ovr || !m_start) ? FCG_DUTY_FULL : (pwm_dis[c] ? FCG_DUTY_OFF : auto_duty[c*8 +: 8]);
        end
        return r;
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Write through the host model, then mirror the effect in the model
    task automatic mwr(input logic [7:0] a, input logic [7:0] v);
        host.wr_byte(a, v);
        if (a == 8'h40) begin
            m_start = v[0];
            m_lock = m_lock | v[1];
            m_ovr = v[3];
        end else if (a >= 8'h5C && a <= 8'h6E && !m_lock) begin
            mem[a - 8'h5C] = int'(v);
        end
    endtask

    task automatic mrd(input logic [7:0] a);
        logic [23:0] dt;
        logic [7:0]  e;
        dt = exp_duty();
        e = 8'h00;
        if (a == 8'h40) e = {4'h0, m_ovr, m_ready, m_lock, m_start};
        else if (a >= 8'h5C && a <= 8'h6E) e = mem[a - 8'h5C][7:0];
        else if (a >= 8'h30 && a <= 8'h32) e = dt[(a - 8'h30)*8 +: 8];
        host.rd_byte(a, d);
        chk({16'h0000, d}, {16'h0000, e});
    endtask

    task automatic chk_param(input int i);
        @(posedge clk);
        #1 param_idx = i[4:0];
        @(posedge clk);
        #1 chk({16'h0000, param_data}, {16'h0000, m_start ? mem[i][7:0] : FCG_PARAM_DEFAULTS[i*8 +: 8]});
    endtask

    // Random algorithm duties and disabled masks, two edges to settle each
    task automatic duty_round();
        repeat (4) begin
            @(posedge clk);
            #1 tmp = rnd();
            auto_duty = tmp[23:0];
            pwm_dis = tmp[26:24];
            repeat (2) @(posedge clk);
            #1 chk(pwm_duty, exp_duty());
        end
    endtask

    task automatic do_reset();
        nrst = 1'b0;
        {m_start, m_lock, m_ovr, m_ready} = 4'h0;
        repeat (12) @(posedge clk);
        #1 nrst = 1'b1;
    endtask

    // -----------------------------------------------------------------
    // Clock, timeout and main sequence
    // -----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            $display("[FAIL] %0t run did not finish", $time);
            report_and_stop();
        end
    end

    initial begin
        {por_done, adc_ok, param_idx, auto_duty, pwm_dis} = '0;
        ce = 1'b1;
        do_reset();
        chk(pwm_duty, 24'hFF_FFFF);
        mrd(8'h40);
        {por_done, adc_ok} = 2'b11;
        repeat (8) @(posedge clk);
        m_ready = 1'b1;
        mrd(8'h40);
        for (int i = 0; i < 19; i++) begin
            tmp = rnd();
            mwr(8'h5C + i[7:0], tmp[7:0]);
        end
        for (int i = 0; i < 19; i++) chk_param(i);
        for (int c = 0; c < 3; c++) mrd(8'h30 + c[7:0]);
        mwr(8'h40, 8'hF1);
        mrd(8'h40);
        for (int i = 0; i < 19; i++) mrd(8'h5C + i[7:0]);
        for (int i = 0; i < 19; i++) chk_param(i);
        duty_round();
        mwr(8'h40, 8'h09);
        duty_round();
        mwr(8'h40, 8'h0B);
        mwr(8'h5C, ~mem[0][7:0]);
        mrd(8'h5C);
        mwr(8'h40, 8'h00);
        mrd(8'h40);
        duty_round();
        mwr(8'h40, 8'h01);
        mrd(8'h40);
        duty_round();
        // Clock enable low: a gate write and new duties must not be taken
        ce = 1'b0;
        dsave = pwm_duty;
        host.wr_byte(8'h40, 8'h08);
        auto_duty = ~auto_duty;
        repeat (2) @(posedge clk);
        #1 chk(pwm_duty, dsave);
        ce = 1'b1;
        mrd(8'h40);
        mwr(8'h30, 8'h12);
        mrd(8'h30);
        mrd(8'h41);
        do_reset();
        mrd(8'h40);
        report_and_stop();
    end
endmodule // fan_control_gate_register_test
`default_nettype wire

// *** fcg_gate_reg.sv ***
// Fan control gate register: start, lock, ready and full-speed override
//
// How it works
// - Start set: fan logic uses the programmed limit and parameter registers.
// - Start clear: fan logic sees built-in defaults, stored values ignored.
// - Changing start never alters stored limit and parameter contents.
// - Start stays writable and effective whether or not lock is set.
// - With lock set, limit and parameter registers ignore writes until power-off.
// - Lock bit cannot be cleared once set; only reset clears it.
// - Ready bit sets itself once power-up reset done and converters work.
// - Override set drives every PWM output at full duty, lock irrelevant.
// - Override beats a channel's disabled mode; disabled channel still full duty.
// - Before start, duty reads full; after start, duty follows the algorithm.
`timescale 1ns/1ns
`default_nettype none
module fcg_gate_reg
    import fcg_pkg::*;
#(
    parameter int PWM_CNT = FCG_PWM_CNT                // PWM channels
) (
    input  wire logic                    CLK,          // 10 MHz system clock
    input  wire logic                    NRST,         // Power-on reset, active low
    input  wire logic                    CE,           // Clock enable, freezes all state
    input  wire logic [7:0]              REG_ADDR,     // Register offset from bus engine
    input  wire logic                    REG_WR,       // Write strobe, one cycle
    input  wire logic                    REG_RD,       // Read strobe, one cycle
    input  wire logic [7:0]              REG_WDATA,    // Write data
    output logic      [7:0]              REG_RDATA,    // Read data, next cycle
    input  wire logic                    POR_DONE,     // Analog power-up reset finished
    input  wire logic                    ADC_OK,       // Converters running correctly
    input  wire logic [FCG_PARAM_AW-1:0] PARAM_IDX,    // Fan logic parameter index
    output logic      [7:0]              PARAM_DATA,   // Parameter value in effect
    input  wire logic [PWM_CNT*8-1:0]    AUTO_DUTY,    // Duties from the fan algorithm
    input  wire logic [PWM_CNT-1:0]      PWM_DISABLED, // Channel in disabled mode
    output logic      [PWM_CNT*8-1:0]    PWM_DUTY,     // Duty applied to each PWM
    output logic                         CTRL_START,   // Programmed values in use
    output logic                         CTRL_LOCKED   // Protected registers locked
);
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic in_param(input logic [7:0] a);
        return (a >= FCG_PARAM_FIRST) && (a <= FCG_PARAM_LAST);
    endfunction

    function automatic logic [FCG_PARAM_AW-1:0] param_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - FCG_PARAM_FIRST;
        return d[FCG_PARAM_AW-1:0];
    endfunction

    function automatic logic [7:0] default_of(input logic [FCG_PARAM_AW-1:0] i);
        return (int'(i) < FCG_PARAM_CNT) ? FCG_PARAM_DEFAULTS[int'(i)*8 +: 8] : FCG_DUTY_OFF;
    endfunction

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    logic                 start_reg,   start_next;
    logic                 lock_reg,    lock_next;
    logic                 ovr_reg,     ovr_next;
    logic                 ready_reg;
    logic [1:0]           por_sync_reg;
    logic [1:0]           adc_sync_reg;
    logic [7:0]           rd_local_reg, rd_local_next;
    logic                 rd_mem_reg;
    logic                 sel_start_reg;
    logic [7:0]           def_reg;
    logic [PWM_CNT*8-1:0] duty_reg,    duty_next;
    logic [7:0]           mem_a_data;
    logic [7:0]           mem_b_data;

    // -----------------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------------
    wire gate_hit  = (REG_ADDR == FCG_GATE_ADDR);
    wire param_hit = in_param(REG_ADDR);
    wire duty_hit  = (REG_ADDR >= FCG_DUTY_FIRST) &&
                     (REG_ADDR < FCG_DUTY_FIRST + 8'(PWM_CNT));
    wire gate_wr   = CE && REG_WR && gate_hit;
    // Locked range refuses the write outright; stored contents stay put
    wire mem_we    = REG_WR && param_hit && !lock_reg;
    wire [7:0] gate_view = {FCG_RSVD_VALUE, ovr_reg, ready_reg, lock_reg, start_reg};
    wire [7:0] duty_off  = REG_ADDR - FCG_DUTY_FIRST;

    // -----------------------------------------------------------------
    // Gate bit updates
    // -----------------------------------------------------------------
    // Start and override follow every write, lock has no say over them
    assign start_next = gate_wr ? REG_WDATA[FCG_START_BIT] : start_reg;
    assign ovr_next   = gate_wr ? REG_WDATA[FCG_OVR_BIT]   : ovr_reg;
    // Lock only ever sets; a written zero is simply not seen
    assign lock_next  = lock_reg | (gate_wr & REG_WDATA[FCG_LOCK_BIT]);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            start_reg <= FCG_GATE_RESET[FCG_START_BIT];
            lock_reg  <= FCG_GATE_RESET[FCG_LOCK_BIT];
            ovr_reg   <= FCG_GATE_RESET[FCG_OVR_BIT];
        end else if (CE) begin
            start_reg <= start_next;
            lock_reg  <= lock_next;
            ovr_reg   <= ovr_next;
        end
    end

    // -----------------------------------------------------------------
    // Ready: analog status crosses in through two flops each
    // -----------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            por_sync_reg <= 2'b00;
            adc_sync_reg <= 2'b00;
            ready_reg    <= FCG_GATE_RESET[FCG_READY_BIT];
        end else if (CE) begin
            por_sync_reg <= {por_sync_reg[0], POR_DONE};
            adc_sync_reg <= {adc_sync_reg[0], ADC_OK};
            ready_reg    <= por_sync_reg[1] & adc_sync_reg[1];
        end
    end

    // -----------------------------------------------------------------
    // Protected storage; start has no path into it
    // -----------------------------------------------------------------
    fcg_param_mem #(
        .W       (8),
        .DEPTH   (FCG_PARAM_CNT),
        .AW      (FCG_PARAM_AW)
    ) u_mem (
        .clk       (CLK),
        .ce        (CE),
        .we        (mem_we),
        .wr_idx    (param_idx(REG_ADDR)),
        .wr_data   (REG_WDATA),
        .rd_a_idx  (param_idx(REG_ADDR)),
        .rd_a_data (mem_a_data),
        .rd_b_idx  (PARAM_IDX),
        .rd_b_data (mem_b_data)
    );

    // Fan logic sees defaults until start is set, in step with the memory read
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sel_start_reg <= 1'b0;
            def_reg       <= FCG_DUTY_OFF;
        end else if (CE) begin
            sel_start_reg <= start_reg;
            def_reg       <= default_of(PARAM_IDX);
        end
    end
    assign PARAM_DATA = sel_start_reg ? mem_b_data : def_reg;

    // -----------------------------------------------------------------
    // PWM duty: override, then pre-start full, then disabled, then auto
    // -----------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < PWM_CNT; c++) begin
            if (ovr_reg) begin
                duty_next[c*8 +: 8] = FCG_DUTY_FULL;
            end else if (!start_reg) begin
                duty_next[c*8 +: 8] = FCG_DUTY_FULL;
            end else if (PWM_DISABLED[c]) begin
                duty_next[c*8 +: 8] = FCG_DUTY_OFF;
            end else begin
                duty_next[c*8 +: 8] = AUTO_DUTY[c*8 +: 8];
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            duty_reg <= {PWM_CNT{FCG_DUTY_FULL}};
        end else if (CE) begin
            duty_reg <= duty_next;
        end
    end
    assign PWM_DUTY = duty_reg;

    // -----------------------------------------------------------------
    // Host read path, one cycle after the strobe
    // -----------------------------------------------------------------
    // Unmapped offsets read zero rather than stale data
    assign rd_local_next = gate_hit ? gate_view :
                           duty_hit ? duty_reg[int'(duty_off[1:0])*8 +: 8] : 8'h00;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rd_local_reg <= 8'h00;
            rd_mem_reg   <= 1'b0;
        end else if (CE && REG_RD) begin
            rd_local_reg <= rd_local_next;
            rd_mem_reg   <= param_hit;
        end
    end
    assign REG_RDATA   = rd_mem_reg ? mem_a_data : rd_local_reg;
    assign CTRL_START  = start_reg;
    assign CTRL_LOCKED = lock_reg;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    sequence start_one_s;
        CE && REG_WR && gate_hit && REG_WDATA[FCG_START_BIT];
    endsequence
    sequence analog_up_s;
        (CE && POR_DONE && ADC_OK)[*3];
    endsequence

    start_takes_a: assert property (start_one_s |=> start_reg)
        else $error("start bit not set by write");
    defaults_used_a: assert property ((CE && !start_reg) |=> PARAM_DATA == default_of($past(PARAM_IDX)))
        else $error("stored parameter leaked before start");
    gate_no_mem_a: assert property ((REG_WR && gate_hit) |-> !mem_we)
        else $error("gate write touched parameter storage");
    lock_blocks_a: assert property (lock_reg |-> !mem_we)
        else $error("write accepted while locked");
    lock_sticky_a: assert property (lock_reg |=> lock_reg[*3])
        else $error("lock bit cleared");
    ready_sets_a: assert property (analog_up_s |=> ready_reg)
        else $error("ready not set after analog came up");
    ovr_full_a: assert property ((CE && ovr_reg && |PWM_DISABLED) |=> PWM_DUTY == {PWM_CNT{FCG_DUTY_FULL}})
        else $error("override did not force full duty");
    rsvd_zero_a: assert property ((CE && REG_RD && gate_hit) |=> REG_RDATA[7:4] == FCG_RSVD_VALUE)
        else $error("reserved bits not zero");
    prestart_full_a: assert property ((CE && !start_reg) |=> PWM_DUTY == {PWM_CNT{FCG_DUTY_FULL}})
        else $error("duty not full before start");
    auto_follow_a: assert property ((CE && start_reg && !ovr_reg && PWM_DISABLED == '0)
                                    |=> PWM_DUTY == $past(AUTO_DUTY))
        else $error("duty not following algorithm");
endmodule // fcg_gate_reg
`default_nettype wire

// *** fcg_host_model.sv ***
// Host-side bus engine model issuing single-byte register strobes
`timescale 1ns/1ns
`default_nettype none
module fcg_host_model (
    input  wire logic       clk,    // System clock
    output logic      [7:0] addr,   // Register offset
    output logic            wr,     // Write strobe
    output logic            rd,     // Read strobe
    output logic      [7:0] wdata,  // Write data
    input  wire logic [7:0] rdata   // Read data from the gate block
);
    // Idle bus at time zero
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // One-cycle write; address and data are inverted once released so stale values never look valid
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask

    // One-cycle read; data is registered, so it is settled just after the taking edge
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        addr = ~a;
        d = rdata;
    endtask
endmodule // fcg_host_model
`default_nettype wire

// *** fcg_param_mem.sv ***
// Limit and parameter storage with one write port and two registered read ports
`timescale 1ns/1ns
`default_nettype none
module fcg_param_mem #(
    parameter int W     = 8,                          // Word width
    parameter int DEPTH = 19,                         // Words
    parameter int AW    = 5                           // Index width
) (
    input  wire logic          clk,                   // System clock
    input  wire logic          ce,                    // Clock enable
    input  wire logic          we,                    // Write strobe
    input  wire logic [AW-1:0] wr_idx,                // Write index
    input  wire logic [W-1:0]  wr_data,               // Write data
    input  wire logic [AW-1:0] rd_a_idx,              // Host read index
    output logic      [W-1:0]  rd_a_data,             // Host read data, registered
    input  wire logic [AW-1:0] rd_b_idx,              // Fan logic read index
    output logic      [W-1:0]  rd_b_data              // Fan logic read data, registered
);
    logic [W-1:0] mem [DEPTH];

    // -----------------------------------------------------------------
    // Storage; no reset, contents only change on an accepted write
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // Both read ports registered; out-of-range indices read zero
    always_ff @(posedge clk) begin
        if (ce) begin
            rd_a_data <= (int'(rd_a_idx) < DEPTH) ? mem[rd_a_idx] : '0;
            rd_b_data <= (int'(rd_b_idx) < DEPTH) ? mem[rd_b_idx] : '0;
        end
    end
endmodule // fcg_param_mem
`default_nettype wire

// *** fcg_pkg.sv ***
// Package: register map, field layout and reset values of the fan control gate
package fcg_pkg;
    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] FCG_GATE_ADDR   = 8'h40;   // Gate register offset
    localparam logic [7:0] FCG_PARAM_FIRST = 8'h5C;   // First limit/parameter register
    localparam logic [7:0] FCG_PARAM_LAST  = 8'h6E;   // Last limit/parameter register
    localparam logic [7:0] FCG_DUTY_FIRST  = 8'h30;   // Current duty, channel 1
    localparam int         FCG_PARAM_CNT   = 19;      // Registers in the protected range
    localparam int         FCG_PARAM_AW    = 5;       // Index width for that range
    localparam int         FCG_PWM_CNT     = 3;       // PWM channels

    // -----------------------------------------------------------------
    // Gate register fields and reset
    // -----------------------------------------------------------------
    localparam int         FCG_START_BIT   = 0;
    localparam int         FCG_LOCK_BIT    = 1;
    localparam int         FCG_READY_BIT   = 2;
    localparam int         FCG_OVR_BIT     = 3;
    localparam logic [7:0] FCG_GATE_RESET  = 8'h00;
    localparam logic [3:0] FCG_RSVD_VALUE  = 4'h0;    // Bits 7..4 read back as this

    // -----------------------------------------------------------------
    // Duty values and built-in defaults
    // -----------------------------------------------------------------
    localparam logic [7:0] FCG_DUTY_FULL   = 8'hFF;   // 100 % duty
    localparam logic [7:0] FCG_DUTY_OFF    = 8'h00;   // Disabled channel
    // Defaults used while start is clear, one byte per index, index 0 lowest
    localparam logic [FCG_PARAM_CNT*8-1:0] FCG_PARAM_DEFAULTS = '0;
endpackage : fcg_pkg
